// *** logic/eesp_core.v ***
// Purpose: serial eeprom command decoder, status byte and write engine
// Assumes: pins sampled by clk through two flip-flops
// Notes: array, id page and page buffer are held here
//
// Contract
// [R01] sample serial input on every rising serial clock edge, both modes
// [R02] change serial output on falling serial clock edges when returning data
// [R03] output off while select high; standby unless internal write runs
// [R04] host frames each transaction with select falling then rising
// [R05] host pauses with hold low, resumes high, serial clock low
// [R06] first eight bits are opcode; decode set/clear enable, read status
// [R07] decode write status, read, write; ignore any other code
// [R08] status byte: hwpe, idsel, zero, lock, bp hi, bp lo, wel, busy
// [R09] busy reads one during internal write; host cannot write it
// [R10] enable latch set by set command, cleared by clear command
// [R11] block protect bits choose none, quarter, half or full range
// [R12] protected addresses never written; others need enable latch
// [R13] status write needs enable latch; locked by hwpe with protect low
// [R14] id select steers access to id page; clears after access
// [R15] id lock once set makes id page read only forever
// [R16] setting id select and id lock together changes neither
// [R17] power-up leaves enable latch clear
// [R18] enable latch set only on select rise right after opcode
// [R19] write is opcode, 16-bit address, data; low 14 bits used
// [R20] internal programming starts on select rise ending valid write
// [R21] during internal write ignore all but read status
// [R22] internal write completes within 5 ms of select rise
// [R23] up to 64 data bytes, page offset wraps within page
// [R24] enable latch clears when internal write completes
// [R25] hold low with select low: output off, input ignored
// [R26] works whether serial clock idles low or high
`timescale 1ns/1ns
`include "eesp_defines.vh"
module eesp_core #(
   parameter WRITE_CYCLES = `EESP_T_WC_NS / `EESP_CLK_NS
) (
   input wire clk,
   input wire arst_n,
   input wire cs_n,
   input wire sck,
   input wire si,
   input wire hold_n,
   input wire wp_n,
   output reg so_out,
   output reg so_oe,
   output reg busy,
   output reg standby,
   output reg [7:0] protection_status_byte
);
   localparam ST_IDLE = 8'h01;
   localparam ST_OPC = 8'h02;
   localparam ST_ADDR = 8'h04;
   localparam ST_WDATA = 8'h08;
   localparam ST_RDATA = 8'h10;
   localparam ST_RSTAT = 8'h20;
   localparam ST_WSTAT = 8'h40;
   localparam ST_IGN = 8'h80;

   // block protect hit for a 14-bit address
   function prot_hit;
      input [1:0] bp;
      input [`EESP_ADDR_W-1:0] a;
      begin
         case (bp)
            `EESP_BP_QUARTER: prot_hit = (a >= `EESP_QUARTER_BASE);
            `EESP_BP_HALF: prot_hit = (a >= `EESP_HALF_BASE);
            `EESP_BP_FULL: prot_hit = 1'b1;
            default: prot_hit = 1'b0;
         endcase
      end
   endfunction

   // read pointer advance, id page wraps within its page
   function [`EESP_ADDR_W-1:0] ptr_next;
      input [`EESP_ADDR_W-1:0] p;
      input id;
      begin
         if (id)
            ptr_next = {p[13:6], p[5:0] + 6'd1};
         else
            ptr_next = p + 14'd1;
      end
   endfunction

   // pin sampling
   wire [4:0] pins_s;
   eesp_sync #(.W(5), .RST(`EESP_PIN_IDLE)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d({cs_n, sck, si, hold_n, wp_n}),
      .q(pins_s)
   );
   wire cs_s = pins_s[4];
   wire sck_s = pins_s[3];
   wire si_s = pins_s[2];
   wire hold_s = pins_s[1];
   wire wp_s = pins_s[0];

   reg sck_d;
   reg cs_d;
   wire live = ~cs_s & hold_s; // [R25]
   wire sck_rise = live & sck_s & ~sck_d; // [R01] [R26]
   wire sck_fall = live & ~sck_s & sck_d; // [R02]
   wire cs_fall = ~cs_s & cs_d;
   wire cs_rise = cs_s & ~cs_d;

   // storage
   reg [7:0] mem [0:`EESP_MEM_WORDS-1];
   reg [7:0] idmem [0:`EESP_PAGE_BYTES-1];
   reg [7:0] pbuf [0:`EESP_PAGE_BYTES-1];
   reg [`EESP_PAGE_BYTES-1:0] pmask;

   // status fields
   reg hw_protect_enable;
   reg id_page_select;
   reg id_page_lock;
   reg block_protect_hi;
   reg block_protect_lo;
   reg write_enable_latch;
   wire [1:0] bp = {block_protect_hi, block_protect_lo};
   wire [7:0] status_now = {hw_protect_enable, id_page_select,
      `EESP_SB_ZERO, id_page_lock, block_protect_hi, block_protect_lo,
      write_enable_latch, busy}; // [R08] [R09]

   // serial front end
   reg [7:0] state;
   reg [7:0] opcode;
   reg [6:0] in_sr;
   reg [2:0] bit_idx;
   reg [7:0] addr_hi;
   reg addr_cnt;
   reg armed;
   reg [7:0] wsr_val;
   reg data_seen;
   reg [`EESP_ADDR_W-1:0] wr_addr;
   reg [5:0] wr_ptr;
   reg wr_id;
   wire [7:0] in_byte = {in_sr, si_s};
   wire byte_done = sck_rise & (bit_idx == 3'd7);

   // read side
   reg rd_go;
   reg rd_id;
   reg [`EESP_ADDR_W-1:0] rd_ptr;
   reg out_go;
   reg out_on;
   reg [6:0] out_sr;
   reg [2:0] out_cnt;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire [7:0] rd_byte = rd_id ? idmem[rd_ptr[5:0]] : mem[rd_ptr];
   wire out_load = sck_fall & out_go & (out_cnt == 3'd0);
   wire fifo_pop = out_load & (state == ST_RDATA);
   wire [7:0] out_byte = (state == ST_RSTAT) ? status_now :
      (fifo_out_valid ? fifo_out_data : 8'hff);

   // programming engine
   reg [20:0] prog_timer;
   reg [6:0] prog_idx;
   reg prog_id;

   // write permission checks
   wire wsr_allowed = write_enable_latch & ~busy &
      ~(hw_protect_enable & ~wp_s); // [R13]
   wire wr_blocked = prot_hit(bp, wr_addr) |
      (wr_id & (id_page_lock | (bp == `EESP_BP_FULL))); // [R12] [R15]
   wire wr_valid = (state == ST_WDATA) & data_seen &
      (bit_idx == 3'd0) & write_enable_latch & ~busy & ~wr_blocked;
   wire wsr_valid = (state == ST_IGN) & armed &
      (opcode == `EESP_OP_WR_STAT) & wsr_allowed;
   wire prog_start = cs_rise & (wr_valid | wsr_valid); // [R20]
   wire prog_end = busy &
      (prog_timer == WRITE_CYCLES[20:0] - 21'd1); // [R22]

   eesp_fifo2 #(.W(8)) u_rdbuf (
      .clk(clk),
      .arst_n(arst_n),
      .flush(cs_rise | cs_fall),
      .in_valid(rd_go),
      .in_ready(fifo_in_ready),
      .in_data(rd_byte),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // input shifter and command sequencing
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sck_d <= 1'b0;
         cs_d <= 1'b1;
         state <= ST_IDLE;
         opcode <= 8'h00;
         in_sr <= 7'h00;
         bit_idx <= 3'd0;
         addr_hi <= 8'h00;
         addr_cnt <= 1'b0;
         armed <= 1'b0;
         wsr_val <= 8'h00;
         data_seen <= 1'b0;
         wr_addr <= {`EESP_ADDR_W{1'b0}};
         wr_ptr <= 6'd0;
         wr_id <= 1'b0;
         pmask <= {`EESP_PAGE_BYTES{1'b0}};
         rd_go <= 1'b0;
         rd_id <= 1'b0;
         rd_ptr <= {`EESP_ADDR_W{1'b0}};
         out_go <= 1'b0;
      end else begin
         sck_d <= sck_s;
         cs_d <= cs_s;
         if (rd_go & fifo_in_ready)
            rd_ptr <= ptr_next(rd_ptr, rd_id);
         if (cs_s) begin
            state <= ST_IDLE;
            rd_go <= 1'b0;
            out_go <= 1'b0;
         end
         if (cs_fall) begin
            state <= ST_OPC;
            bit_idx <= 3'd0;
            armed <= 1'b0;
            addr_cnt <= 1'b0;
            data_seen <= 1'b0;
         end else if (sck_rise) begin
            in_sr <= {in_sr[5:0], si_s}; // [R01]
            bit_idx <= bit_idx + 3'd1;
            if (state == ST_IGN)
               armed <= 1'b0; // [R18]
            if (byte_done) begin
               case (state)
                  ST_OPC: begin
                     opcode <= in_byte; // [R06]
                     if (busy & (in_byte != `EESP_OP_RD_STAT))
                        state <= ST_IGN; // [R21]
                     else begin
                        case (in_byte)
                           `EESP_OP_SET_WE: begin
                              state <= ST_IGN;
                              armed <= 1'b1; // [R18]
                           end
                           `EESP_OP_RD_STAT: begin
                              state <= ST_RSTAT;
                              out_go <= 1'b1;
                           end
                           `EESP_OP_WR_STAT: state <= ST_WSTAT; // [R07]
                           `EESP_OP_READ: state <= ST_ADDR;
                           `EESP_OP_WRITE: state <= ST_ADDR;
                           default: state <= ST_IGN; // [R06] [R07]
                        endcase
                     end
                  end
                  ST_ADDR: begin
                     addr_hi <= in_byte;
                     addr_cnt <= 1'b1;
                     if (addr_cnt) begin
                        if (opcode == `EESP_OP_READ) begin
                           state <= ST_RDATA;
                           rd_ptr <= {addr_hi[5:0], in_byte}; // [R19]
                           rd_id <= id_page_select; // [R14]
                           rd_go <= 1'b1;
                           out_go <= 1'b1;
                        end else begin
                           state <= ST_WDATA;
                           wr_addr <= {addr_hi[5:0], in_byte}; // [R19]
                           wr_ptr <= in_byte[5:0];
                           wr_id <= id_page_select; // [R14]
                           pmask <= {`EESP_PAGE_BYTES{1'b0}};
                        end
                     end
                  end
                  ST_WDATA: begin
                     pmask[wr_ptr] <= 1'b1;
                     wr_ptr <= wr_ptr + 6'd1; // [R23]
                     data_seen <= 1'b1;
                  end
                  ST_WSTAT: begin
                     wsr_val <= in_byte;
                     armed <= 1'b1;
                     state <= ST_IGN;
                  end
                  default: state <= state;
               endcase
            end
         end
      end
   end

   // page buffer load, no reset needed
   always @(posedge clk) begin
      if (byte_done & (state == ST_WDATA))
         pbuf[wr_ptr] <= in_byte; // [R23]
   end

   // status bits and internal write timing
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hw_protect_enable <= 1'b0;
         id_page_select <= 1'b0;
         id_page_lock <= 1'b0;
         block_protect_hi <= 1'b0;
         block_protect_lo <= 1'b0;
         write_enable_latch <= 1'b0; // [R17]
         busy <= 1'b0;
         prog_timer <= 21'd0;
         prog_idx <= `EESP_PAGE_DONE;
         prog_id <= 1'b0;
      end else begin
         if (byte_done & (state == ST_OPC) & ~busy &
             (in_byte == `EESP_OP_CLR_WE))
            write_enable_latch <= 1'b0; // [R10]
         if (cs_rise & armed & (state == ST_IGN) & ~busy &
             (opcode == `EESP_OP_SET_WE))
            write_enable_latch <= 1'b1; // [R10] [R18]
         if (cs_rise & ((state == ST_RDATA) | (state == ST_WDATA)) &
             id_page_select)
            id_page_select <= 1'b0; // [R14]
         if (cs_rise & wsr_valid) begin
            hw_protect_enable <= wsr_val[`EESP_SB_HWPE]; // [R13]
            block_protect_hi <= wsr_val[`EESP_SB_BPHI]; // [R11]
            block_protect_lo <= wsr_val[`EESP_SB_BPLO];
            if (~(wsr_val[`EESP_SB_IDSEL] & wsr_val[`EESP_SB_LOCK])) begin
               id_page_select <= wsr_val[`EESP_SB_IDSEL]; // [R16]
               id_page_lock <= id_page_lock |
                  wsr_val[`EESP_SB_LOCK]; // [R15]
            end
         end
         if (prog_start) begin
            busy <= 1'b1; // [R09] [R20]
            prog_timer <= 21'd0;
            prog_id <= wr_id;
            prog_idx <= wr_valid ? 7'd0 : `EESP_PAGE_DONE;
         end else if (busy) begin
            prog_timer <= prog_timer + 21'd1;
            if (prog_idx != `EESP_PAGE_DONE)
               prog_idx <= prog_idx + 7'd1;
            if (prog_end) begin
               busy <= 1'b0; // [R22]
               write_enable_latch <= 1'b0; // [R24]
            end
         end
      end
   end

   // committing the page buffer, one byte per cycle
   always @(posedge clk) begin
      if (busy & (prog_idx <= `EESP_PAGE_LAST) & pmask[prog_idx[5:0]]) begin
         if (prog_id)
            idmem[prog_idx[5:0]] <= pbuf[prog_idx[5:0]];
         else
            mem[{wr_addr[13:6], prog_idx[5:0]}] <= pbuf[prog_idx[5:0]];
      end
   end

   // serial output, shifted on falling edges
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         so_out <= 1'b0;
         so_oe <= 1'b0;
         out_on <= 1'b0;
         out_sr <= 7'h00;
         out_cnt <= 3'd0;
         standby <= 1'b1;
         protection_status_byte <= 8'h00;
      end else begin
         standby <= cs_s & ~busy; // [R03]
         protection_status_byte <= status_now;
         so_oe <= out_on & live; // [R03] [R25]
         if (cs_s | cs_fall) begin
            out_on <= 1'b0;
            out_cnt <= 3'd0;
         end else if (sck_fall & out_go) begin
            out_on <= 1'b1;
            out_cnt <= out_cnt + 3'd1;
            if (out_cnt == 3'd0) begin
               so_out <= out_byte[7]; // [R02]
               out_sr <= out_byte[6:0];
            end else begin
               so_out <= out_sr[6]; // [R02]
               out_sr <= {out_sr[5:0], 1'b0};
            end
         end
      end
   end
endmodule // eesp_core

// *** logic/eesp_defines.vh ***
// Purpose: shared constants of the serial eeprom command front end
// Assumes: 250 MHz system clock, pins sampled through two flip-flops
// Notes: definitions only
`ifndef EESP_DEFINES_VH
`define EESP_DEFINES_VH

// opcodes
`define EESP_OP_SET_WE 8'h06
`define EESP_OP_CLR_WE 8'h04
`define EESP_OP_RD_STAT 8'h05
`define EESP_OP_WR_STAT 8'h01
`define EESP_OP_READ 8'h03
`define EESP_OP_WRITE 8'h02

// status byte layout
`define EESP_SB_BUSY 0
`define EESP_SB_WEL 1
`define EESP_SB_BPLO 2
`define EESP_SB_BPHI 3
`define EESP_SB_LOCK 4
`define EESP_SB_IDSEL 6
`define EESP_SB_HWPE 7
`define EESP_SB_ZERO 1'b0

// block protect codes and range bases
`define EESP_BP_NONE 2'h0
`define EESP_BP_QUARTER 2'h1
`define EESP_BP_HALF 2'h2
`define EESP_BP_FULL 2'h3
`define EESP_QUARTER_BASE 14'h3000
`define EESP_HALF_BASE 14'h2000

// array geometry
`define EESP_ADDR_W 14
`define EESP_MEM_WORDS 16384
`define EESP_PAGE_BYTES 64
`define EESP_PAGE_LAST 7'h3f
`define EESP_PAGE_DONE 7'h40

// timing
`define EESP_CLK_NS 4
`define EESP_T_WC_NS 5000000

// pin synchroniser idle value {cs_n, sck, si, hold_n, wp_n}
`define EESP_PIN_IDLE 5'h13

`endif

// *** logic/eesp_fifo2.v ***
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock
// Notes: flush empties it in one cycle
`timescale 1ns/1ns
module eesp_fifo2 #(
   parameter W = 8
) (
   input wire clk,
   input wire arst_n,
   input wire flush,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] slot0;
   reg [W-1:0] slot1;
   reg wp;
   reg rp;
   reg [1:0] cnt;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = (cnt != 2'd2);
   assign out_valid = (cnt != 2'd0);
   assign out_data = rp ? slot1 : slot0;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         slot0 <= {W{1'b0}};
         slot1 <= {W{1'b0}};
         wp <= 1'b0;
         rp <= 1'b0;
         cnt <= 2'd0;
      end else if (flush) begin
         wp <= 1'b0;
         rp <= 1'b0;
         cnt <= 2'd0;
      end else begin
         if (push) begin
            if (wp)
               slot1 <= in_data;
            else
               slot0 <= in_data;
            wp <= ~wp;
         end
         if (pop)
            rp <= ~rp;
         if (push & ~pop)
            cnt <= cnt + 2'd1;
         else if (pop & ~push)
            cnt <= cnt - 2'd1;
      end
   end
endmodule // eesp_fifo2

// *** logic/eesp_sync.v ***
// Purpose: two flip-flop synchroniser for the pin inputs
// Assumes: inputs asynchronous to clk
// Notes: reset value is a constant parameter
`timescale 1ns/1ns
module eesp_sync #(
   parameter W = 5,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input wire clk,
   input wire arst_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= RST;
         q <= RST;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // eesp_sync

// *** test/eesp_checker.sv ***
// Purpose: port assertions of the eeprom front end
// Assumes: one clock domain, pins synchronised inside
// Notes: bound from the bench top
`timescale 1ns/1ns
module eesp_checker #(
   parameter WRITE_CYCLES = 1250000
) (
   input wire clk,
   input wire arst_n,
   input wire cs_n,
   input wire sck,
   input wire si,
   input wire hold_n,
   input wire wp_n,
   input wire so_out,
   input wire so_oe,
   input wire busy,
   input wire standby,
   input wire [7:0] protection_status_byte
);
   reg [31:0] busy_cnt;
   wire [31:0] next_busy_cnt;
   assign next_busy_cnt = busy ? busy_cnt + 32'h1 : 32'h0;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         busy_cnt <= 32'h0;
      else
         busy_cnt <= next_busy_cnt;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_desel;
      cs_n [*5];
   endsequence
   sequence s_held;
      (!hold_n && !cs_n) [*5];
   endsequence
   chk_off_desel: assert property (s_desel |-> !so_oe)
      else $error("output driven while deselected");
   chk_standby_idle: assert property (
      s_desel ##0 !busy [*2] |-> standby)
      else $error("no standby while idle");
   chk_off_hold: assert property (s_held |-> !so_oe)
      else $error("output driven during hold");
   chk_so_on_fall: assert property (
      so_oe && $past(so_oe) && $changed(so_out) |-> !sck)
      else $error("output changed with clock high");
   chk_zero_bit: assert property (!protection_status_byte[5])
      else $error("status bit 5 set");
   chk_busy_flag: assert property (
      busy [*2] |-> protection_status_byte[0])
      else $error("busy bit clear while busy");
   chk_busy_len: assert property (
      $fell(busy) |-> busy_cnt == WRITE_CYCLES)
      else $error("write cycle length wrong");
   chk_wel_done: assert property (
      $fell(busy) |-> ##1 !protection_status_byte[1])
      else $error("enable kept after write cycle");
   chk_busy_start: assert property (
      $rose(busy) |-> cs_n && $past(protection_status_byte[1]))
      else $error("write started without enable or select");
   chk_wel_on_rise: assert property (
      $rose(protection_status_byte[1]) |-> cs_n)
      else $error("enable set inside a frame");
   chk_wel_busy: assert property (
      busy [*2] |-> $stable(protection_status_byte[1]))
      else $error("enable changed while busy");
   chk_lock_kept: assert property (
      $past(protection_status_byte[4]) |-> protection_status_byte[4])
      else $error("lock bit cleared");
endmodule // eesp_checker

// *** test/eesp_host.sv ***
// Purpose: host controller model driving the serial pins
// Assumes: inputs change at clk falling edges, 124 ns serial clock
// Notes: released output shows the inverse of its last value
`timescale 1ns/1ns
module eesp_host (
   input wire clk,
   output reg cs_n,
   output reg sck,
   output reg si,
   output reg hold_n,
   input wire so_out,
   input wire so_oe
);
   reg so_last;
   reg m3;
   wire so_line;
   assign so_line = so_oe ? so_out : ~so_last;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
      so_last = 1'b0;
      m3 = 1'b0;
   end
   always @(posedge clk) if (so_oe) so_last <= so_out;
   // data line wanders while deselected
   always @(negedge clk) if (cs_n) si <= ~si;
   task wt(input integer n);
      integer k;
      for (k = 0; k < n; k = k + 1) @(negedge clk);
   endtask
   task open(input mode3);
      begin
         wt(1);
         sck = mode3;
         m3 = mode3;
         wt(4);
         cs_n = 1'b0; // frame start
         wt(8);
      end
   endtask
   task xbyte(input [7:0] tx, output [7:0] rx);
      integer i;
      for (i = 7; i >= 0; i = i - 1) begin
         sck = 1'b0;
         si = tx[i]; // msb first, address high byte first
         wt(15);
         sck = 1'b1;
         rx[i] = so_line;
         wt(16);
      end
   endtask
   task close;
      begin
         sck = m3;
         wt(8);
         cs_n = 1'b1; // frame end, straight after last byte
         wt(12);
      end
   endtask
   task pause(output oe_seen);
      integer p;
      begin
         sck = 1'b0; // clock low at both hold edges
         wt(8);
         hold_n = 1'b0;
         wt(8);
         oe_seen = so_oe;
         si = 1'b1;
         for (p = 0; p < 3; p = p + 1) begin
            sck = 1'b1;
            wt(15);
            sck = 1'b0;
            wt(15);
         end
         hold_n = 1'b1;
         wt(8);
      end
   endtask
endmodule // eesp_host

// *** test/eesp_tb.sv ***
// Purpose: self-checking bench of the eeprom front end
// Assumes: host model on the pins, shortened write cycle
// Notes: scenarios run in order on shared state
`timescale 1ns/1ns
`define CHK(a, e) begin \
   n_checks = n_checks + 1; \
   if ((a) !== (e)) begin \
      n_mismatch = n_mismatch + 1; \
      $display("wrong value at %0t: %h not %h", $time, a, e); \
   end end
module tb;
   localparam WC = 1000;
   reg clk, arst_n, wp_n, m3, oe_mid;
   integer n_checks, n_mismatch, cyc, j;
   reg [7:0] tx [0:7];
   reg [7:0] rx [0:7];
   wire cs_n, sck, si, hold_n, so_out, so_oe, busy, standby;
   wire [7:0] psb;
   eesp_core #(.WRITE_CYCLES(WC)) eesp_core_i (.clk(clk), .arst_n(arst_n),
      .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
      .so_out(so_out), .so_oe(so_oe), .busy(busy), .standby(standby),
      .protection_status_byte(psb));
   eesp_host eesp_host_i (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
      .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe));
   task frame(input integer n);
      integer i;
      begin
         eesp_host_i.open(m3);
         for (i = 0; i < n; i = i + 1) eesp_host_i.xbyte(tx[i], rx[i]);
         eesp_host_i.close;
      end
   endtask
   task send(input integer n, input [7:0] b0, b1, b2, b3);
      begin
         tx[0] = b0;
         tx[1] = b1;
         tx[2] = b2;
         tx[3] = b3;
         frame(n);
      end
   endtask
   task idle;
      integer k;
      begin
         for (k = 0; busy !== 1'b0 && k < 1200; k = k + 1) @(negedge clk);
         `CHK(busy, 1'b0)
      end
   endtask
   task rds;
      send(2, 8'h05, 8'h00, 8'h00, 8'h00);
   endtask
   task set_we;
      send(1, 8'h06, 8'h00, 8'h00, 8'h00);
   endtask
   task wsr(input [7:0] v);
      begin
         set_we;
         send(2, 8'h01, v, 8'h00, 8'h00);
         idle;
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      begin
         set_we;
         send(4, 8'h02, a[15:8], a[7:0], d);
         idle;
      end
   endtask
   task rd(input [15:0] a);
      send(4, 8'h03, a[15:8], a[7:0], 8'h00);
   endtask
   task t_power;
      begin
         `CHK(standby, 1'b1)
         rds;
         `CHK(rx[1], 8'h00)
         $display("test power done");
      end
   endtask
   task t_enable;
      begin
         m3 = 1'b1;
         set_we;
         rds;
         `CHK(rx[1], 8'h02)
         eesp_host_i.open(m3);
         eesp_host_i.xbyte(8'h05, rx[0]);
         eesp_host_i.pause(oe_mid);
         eesp_host_i.xbyte(8'h00, rx[1]);
         eesp_host_i.close;
         `CHK(oe_mid, 1'b0)
         `CHK(rx[1], 8'h02)
         send(1, 8'h04, 8'h00, 8'h00, 8'h00);
         rds;
         `CHK(rx[1], 8'h00)
         send(2, 8'h06, 8'h00, 8'h00, 8'h00);
         rds;
         `CHK(rx[1], 8'h00)
         for (j = 0; j < 3; j = j + 1) begin
            eesp_host_i.open(m3);
            eesp_host_i.xbyte(8'h07 + 8'h40 * j[7:0], rx[0]);
            eesp_host_i.xbyte(8'h00, rx[1]);
            `CHK(so_oe, 1'b0)
            eesp_host_i.close;
         end
         $display("test enable done");
      end
   endtask
   task t_write;
      begin
         m3 = 1'b0;
         set_we;
         tx[0] = 8'h02;
         tx[1] = 8'hc0;
         tx[2] = 8'h3e;
         tx[3] = 8'ha1;
         tx[4] = 8'ha2;
         tx[5] = 8'ha3;
         frame(6);
         `CHK(busy, 1'b1)
         `CHK(standby, 1'b0)
         send(1, 8'h04, 8'h00, 8'h00, 8'h00);
         rds;
         `CHK(rx[1], 8'h03)
         idle;
         rds;
         `CHK(rx[1], 8'h00)
         tx[4] = 8'h00;
         send(5, 8'h03, 8'h00, 8'h3e, 8'h00);
         `CHK(rx[3], 8'ha1)
         `CHK(rx[4], 8'ha2)
         rd(16'h0000);
         `CHK(rx[3], 8'ha3)
         $display("test write done");
      end
   endtask
   task t_protect;
      begin
         m3 = 1'b1;
         wr(16'h3000, 8'h55);
         wsr(8'h04);
         rds;
         `CHK(rx[1], 8'h04)
         wr(16'h3000, 8'haa);
         wr(16'h2fff, 8'h66);
         rd(16'h3000);
         `CHK(rx[3], 8'h55)
         rd(16'h2fff);
         `CHK(rx[3], 8'h66)
         send(4, 8'h02, 8'h00, 8'h00, 8'hbb);
         rd(16'h0000);
         `CHK(rx[3], 8'ha3)
         wsr(8'h08);
         wr(16'h2fff, 8'h77);
         rd(16'h2fff);
         `CHK(rx[3], 8'h66)
         wsr(8'h0c);
         wr(16'h0000, 8'h11);
         rd(16'h0000);
         `CHK(rx[3], 8'ha3)
         wsr(8'h00);
         $display("test protect done");
      end
   endtask
   task t_hw;
      begin
         wsr(8'h84);
         rds;
         `CHK(rx[1], 8'h84)
         wp_n = 1'b0;
         wsr(8'h00);
         rds;
         `CHK(rx[1] & 8'hfd, 8'h84)
         wp_n = 1'b1;
         send(1, 8'h04, 8'h00, 8'h00, 8'h00);
         send(2, 8'h01, 8'h00, 8'h00, 8'h00);
         rds;
         `CHK(rx[1], 8'h84)
         wsr(8'h00);
         rds;
         `CHK(rx[1], 8'h00)
         $display("test hw done");
      end
   endtask
   task t_id;
      begin
         wsr(8'h50);
         rds;
         `CHK(rx[1], 8'h00)
         wsr(8'h40);
         wr(16'h0000, 8'h77);
         rds;
         `CHK(rx[1], 8'h00)
         rd(16'h0000);
         `CHK(rx[3], 8'ha3)
         wsr(8'h40);
         rd(16'h0000);
         `CHK(rx[3], 8'h77)
         wsr(8'h10);
         wsr(8'h40);
         wr(16'h0000, 8'h11);
         wsr(8'h40);
         rd(16'h0000);
         `CHK(rx[3], 8'h77)
         $display("test id done");
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 95000) begin
         n_mismatch = n_mismatch + 1;
         summarize;
      end
   end
   initial begin
      arst_n = 1'b0;
      wp_n = 1'b1;
      m3 = 1'b0;
      n_checks = 0;
      n_mismatch = 0;
      cyc = 0;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_power;
      t_enable;
      t_write;
      t_protect;
      t_hw;
      t_id;
      summarize;
   end
endmodule // tb
bind eesp_core eesp_checker #(.WRITE_CYCLES(WRITE_CYCLES)) eesp_checker_i (
   .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si),
   .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
   .busy(busy), .standby(standby),
   .protection_status_byte(protection_status_byte));
